// >>> common/adcct_pkg.sv
package adcct_pkg;

	// Register indices; byte offset from the module base is four times the index
	localparam logic [5:0] IDX_RSVD_A = 6'h00;
	localparam logic [5:0] IDX_RSVD_B = 6'h01;
	localparam logic [5:0] IDX_CTRL = 6'h02;
	localparam logic [5:0] IDX_R6H = 6'h1C;
	localparam logic [5:0] IDX_R6L = 6'h1D;
	localparam logic [5:0] IDX_R7H = 6'h1E;
	localparam logic [5:0] IDX_R7L = 6'h1F;
	localparam logic [5:0] IDX_CHAN_STAT = 6'h20;
	localparam logic [5:0] IDX_EVT_STAT = 6'h21;
	localparam logic [5:0] IDX_EVT_CLR = 6'h22;
	localparam logic [5:0] IDX_EVT_EN = 6'h23;

	// Control register fields
	localparam int CTL_PWR = 7;
	localparam int CTL_FCLR = 6;
	localparam int CTL_WPD = 5;
	localparam int CTL_TLE = 4;
	localparam int CTL_TPOL = 3;
	localparam int CTL_TEN = 2;
	localparam int CTL_IE = 1;
	localparam logic [7:1] CTRL_RESET = 7'h00;

	// Event status, clear and enable layout
	localparam int NUM_EVT = 2;
	localparam int EVT_SEQ = 0;
	localparam int EVT_TRIG = 1;
	localparam logic [NUM_EVT-1:0] EVT_RESET = 2'h0;

	// Result channels held here
	localparam int RES_W = 10;
	localparam int CHAN_W = 3;
	localparam int NUM_CHAN = 2;
	localparam int FIRST_CHAN = 6;
	localparam logic [9:0] RES_RESET = 10'h000;

	// Bus constants
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// Analog recovery after power up or wait exit
	localparam int CLK_PERIOD_NS = 4;
	localparam int RECOVERY_NS = 1000;
	localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RCV_W = 9;

	typedef enum {PWR_OFF, PWR_RECOVER, PWR_READY} adcct_pwr_e;

endpackage : adcct_pkg

// >>> dv/adcct_core_model.sv
`timescale 1ns/100ps
module adcct_core_model
	import adcct_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic conv_enable,
	input wire logic conv_settled,
	input wire logic conv_abort,
	input wire logic req,
	input wire logic slow,
	input wire logic [CHAN_W-1:0] req_chan,
	input wire logic [RES_W-1:0] req_data,
	output logic seq_done,
	output logic res_valid,
	output logic [CHAN_W-1:0] res_chan,
	output logic [RES_W-1:0] res_data
);
	logic busy;
	logic [3:0] cnt;
	logic [CHAN_W-1:0] ch_q;
	logic [RES_W-1:0] d_q;
	// Outside a result the lines show the inverse of the last value
	assign res_data = res_valid ? d_q : ~d_q;
	assign res_chan = res_valid ? ch_q : ~ch_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy <= 1'b0;
			cnt <= 4'h0;
			ch_q <= 3'h0;
			d_q <= 10'h000;
			res_valid <= 1'b0;
			seq_done <= 1'b0;
		end else begin
			res_valid <= 1'b0;
			seq_done <= res_valid;
			if (conv_abort) begin
				busy <= 1'b0;
			end else if (req) begin
				busy <= 1'b1;
				cnt <= slow ? 4'h9 : 4'h1;
				ch_q <= req_chan;
				d_q <= req_data;
			end else if (busy && conv_enable && conv_settled) begin
				cnt <= cnt - 4'h1;
				busy <= cnt != 4'h0;
				res_valid <= cnt == 4'h0;
			end
		end
	end
endmodule : adcct_core_model

// >>> dv/adcct_tb_top.sv
`timescale 1ns/100ps
module adcct_tb_top
	import adcct_pkg::*;
;
	localparam logic [31:0] BASE = 32'h0000_4000;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = HSIZE_WORD;
	logic wait_mode = 1'b0, trig_pin = 1'b1, req = 1'b0, slow = 1'b0;
	logic [CHAN_W-1:0] req_chan = 3'h6;
	logic [RES_W-1:0] req_data = 10'h000;
	logic hready, hreadyout, hresp, irq, seq_done, res_valid;
	logic conv_enable, conv_settled, conv_abort, conv_trigger;
	logic [31:0] hrdata;
	logic [CHAN_W-1:0] res_chan;
	logic [RES_W-1:0] res_data;
	logic [31:0] exp_q[$];
	int err_count = 0;
	int checks_done = 0;
	assign hready = hreadyout;
	adcct_top #(.BASE_ADDR(BASE)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.wait_mode(wait_mode), .trig_pin(trig_pin), .seq_done(seq_done),
		.res_valid(res_valid), .res_chan(res_chan), .res_data(res_data),
		.conv_enable(conv_enable), .conv_settled(conv_settled), .conv_abort(conv_abort),
		.conv_trigger(conv_trigger), .irq(irq));
	adcct_core_model model (.hclk(hclk), .hresetn(hresetn), .conv_enable(conv_enable),
		.conv_settled(conv_settled), .conv_abort(conv_abort), .req(req), .slow(slow),
		.req_chan(req_chan), .req_data(req_data), .seq_done(seq_done),
		.res_valid(res_valid), .res_chan(res_chan), .res_data(res_data));
	initial begin
		forever #2 hclk = ~hclk;
	end
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	always @(posedge hclk) begin
		if (rd_ph && hready === 1'b1) begin
			chk("hrdata", exp_q.pop_front(), hrdata);
			chk("hresp", 32'h0, hresp);
		end
	end
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (hready !== 1'b1) begin
			err_count++;
			conclude();
		end
	endtask : wait_rdy
	// Address phase, then data phase; nothing is driven twice in one time step
	task automatic bus(input logic wr, input logic [5:0] ix, input logic [31:0] wd,
			input logic [31:0] ex);
		hsel <= 1'b1;
		haddr <= BASE + {24'h0, ix, 2'b00};
		hwrite <= wr;
		htrans <= 2'b10;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= wd;
		rd_ph <= !wr;
		if (!wr) exp_q.push_back(ex);
		wait_rdy();
		rd_ph <= 1'b0;
	endtask : bus
	task automatic wait_hi(input int sel, input int lim, output int n);
		logic s;
		n = 0;
		do begin
			@(posedge hclk);
			#1;
			n++;
			s = sel == 0 ? conv_settled : sel == 1 ? conv_trigger : res_valid;
		end while (s !== 1'b1 && n < lim);
		chk("wait_hi", 32'h1, {31'h0, s});
		if (s !== 1'b1) conclude();
	endtask : wait_hi
	task automatic start(input int c, input logic [9:0] d, input logic s);
		repeat (2) @(posedge hclk);
		req <= 1'b1;
		req_chan <= 3'(c);
		req_data <= d;
		slow <= s;
		@(posedge hclk);
		req <= 1'b0;
	endtask : start
	initial begin
		int n;
		logic [9:0] d;
		logic [5:0] ix;
		void'($urandom(32'hE932));
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		#1;
		chk("irq", 32'h0, irq);
		bus(1'b0, IDX_CTRL, 32'h0, 32'h0);
		for (int i = 0; i < 3; i++) begin
			ix = (i == 2) ? 6'h30 : IDX_RSVD_A + 6'(i);
			bus(1'b1, ix, $urandom, 32'h0);
			bus(1'b0, ix, 32'h0, 32'h0);
		end
		bus(1'b1, IDX_CTRL, 32'h81, 32'h0);
		#1;
		chk("conv_abort", 32'h1, conv_abort);
		chk("conv_enable", 32'h0, conv_enable);
		@(posedge hclk);
		#1;
		chk("conv_abort", 32'h0, conv_abort);
		chk("conv_enable", 32'h1, conv_enable);
		wait_hi(0, RECOVERY_CYC + 9, n);
		chk("recovery", 32'h1, n == RECOVERY_CYC);
		bus(1'b0, IDX_CTRL, 32'h0, 32'h80);
		// Channel 6 and 7 results are read first with fast clear off, then with it on
		for (int m = 0; m < 2; m++) begin
			bus(1'b1, IDX_CTRL, m ? 32'hC0 : 32'h80, 32'h0);
			for (int c = 6; c < 8; c++) begin
				d = 10'($urandom);
				ix = IDX_R6H + 6'(2 * c - 12);
				start(c, d, m[0]);
				wait_hi(2, RECOVERY_CYC + 40, n);
				repeat (2) @(posedge hclk);
				bus(1'b0, ix, 32'h0, {30'h0, d[9:8]});
				bus(1'b0, IDX_CHAN_STAT, 32'h0, m ? 32'h0 : 32'h1 << c);
				bus(1'b0, ix + 6'h1, 32'h0, {24'h0, d[7:0]});
				bus(1'b0, IDX_CHAN_STAT, 32'h0, 32'h0);
			end
		end
		bus(1'b0, IDX_CTRL, 32'h0, 32'hC0);
		bus(1'b1, IDX_CTRL, 32'hC3, 32'h0);
		#1;
		chk("irq", 32'h1, irq);
		bus(1'b0, IDX_CTRL, 32'h0, 32'hC3);
		bus(1'b1, IDX_CTRL, 32'hC0, 32'h0);
		#1;
		chk("irq", 32'h0, irq);
		bus(1'b1, IDX_EVT_EN, 32'h1, 32'h0);
		#1;
		chk("irq", 32'h1, irq);
		bus(1'b1, IDX_EVT_CLR, 32'h1, 32'h0);
		#1;
		chk("irq", 32'h0, irq);
		bus(1'b0, IDX_CTRL, 32'h0, 32'hC2);
		wait_mode <= 1'b1;
		repeat (3) @(posedge hclk);
		#1;
		chk("conv_enable", 32'h1, conv_enable);
		wait_mode <= 1'b0;
		bus(1'b1, IDX_CTRL, 32'hA0, 32'h0);
		d = 10'($urandom);
		start(7, d, 1'b1);
		wait_mode <= 1'b1;
		repeat (3) @(posedge hclk);
		#1;
		chk("conv_enable", 32'h0, conv_enable);
		wait_mode <= 1'b0;
		repeat (3) @(posedge hclk);
		#1;
		chk("conv_enable", 32'h1, conv_enable);
		chk("conv_settled", 32'h0, conv_settled);
		wait_hi(2, RECOVERY_CYC + 40, n);
		repeat (2) @(posedge hclk);
		bus(1'b0, IDX_R7L, 32'h0, {24'h0, d[7:0]});
		for (int k = 0; k < 4; k++) begin
			trig_pin <= !k[0];
			bus(1'b1, IDX_CTRL, 32'h84 | 32'(k << 3), 32'h0);
			repeat (3) @(posedge hclk);
			#1;
			chk("conv_trigger", 32'h0, conv_trigger);
			trig_pin <= k[0];
			wait_hi(1, 4, n);
			repeat (3) @(posedge hclk);
			#1;
			chk("conv_trigger", 32'(k[1]), conv_trigger);
		end
		trig_pin <= 1'b0;
		bus(1'b1, IDX_CTRL, 32'h98, 32'h0);
		trig_pin <= 1'b1;
		repeat (4) @(posedge hclk);
		#1;
		chk("conv_trigger", 32'h0, conv_trigger);
		bus(1'b0, IDX_EVT_STAT, 32'h0, 32'h3);
		bus(1'b1, IDX_EVT_EN, 32'h2, 32'h0);
		#1;
		chk("irq", 32'h1, irq);
		bus(1'b0, IDX_EVT_EN, 32'h0, 32'h2);
		bus(1'b1, IDX_EVT_CLR, 32'h3, 32'h0);
		#1;
		chk("irq", 32'h0, irq);
		bus(1'b0, IDX_EVT_STAT, 32'h0, 32'h0);
		conclude();
	end
endmodule : adcct_tb_top

// >>> rtl/adcct_top.sv
// How it works
// - Both reserved control locations read zero and ignore writes.
// - Writing the control register aborts the running sequence, starting none.
// - Control bit 7 powers converter on; recovery period follows before use.
// - Channel flag clears by status then result read, or with control bit 6 set any result access.
// - Control bit 5 set halts and powers down converter during wait.
// - After wait exit the interrupted conversion resumes; software discards result.
// - Control bit 2 enables external trigger taken from analog channel 7.
// - Bits 4,3 select falling, rising, low level or high level trigger.
// - Control bit 1 enables the sequence-complete interrupt request.
// - Control bit 0 reads sequence-complete flag when enabled, else zero; read-only.
// - Register bus address is module base plus register offset.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
module adcct_top
	import adcct_pkg::*;
#(
	parameter logic [31:0] BASE_ADDR = 32'h0000_0000
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic wait_mode,
	input wire logic trig_pin,
	input wire logic seq_done,
	input wire logic res_valid,
	input wire logic [CHAN_W-1:0] res_chan,
	input wire logic [RES_W-1:0] res_data,
	output logic conv_enable,
	output logic conv_settled,
	output logic conv_abort,
	output logic conv_trigger,
	output logic irq
);

	localparam int RCV_A = RECOVERY_CYC;
	localparam int RCV_A1 = RECOVERY_CYC + 1;

	logic [31:0] offs;
	logic [5:0] idx;
	logic acc;
	logic rd_en;
	logic wr_pend_reg;
	logic wr_pend_next;
	logic [5:0] wr_idx_reg;
	logic [5:0] wr_idx_next;
	logic [7:1] ctrl_reg;
	logic [7:1] ctrl_next;
	logic [NUM_EVT-1:0] evt_reg;
	logic [NUM_EVT-1:0] evt_next;
	logic [NUM_EVT-1:0] evt_clr;
	logic trig_en_reg;
	logic trig_en_next;
	logic abort_reg;
	logic abort_next;
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;
	logic [NUM_CHAN-1:0] chdone_reg;
	logic [RES_W-1:0] res_reg [NUM_CHAN];
	logic halt;
	logic run;
	adcct_pwr_e pwr_reg;
	adcct_pwr_e pwr_next;
	logic [RCV_W-1:0] cnt_reg;
	logic [RCV_W-1:0] cnt_next;
	logic trig_fire;

	assign offs = haddr - BASE_ADDR;
	assign idx = offs[7:2];
	assign acc = hsel & htrans[1] & hready & (offs[31:8] == 24'h00_0000)
		& (hsize == HSIZE_WORD);
	assign rd_en = acc & ~hwrite;

	// Bus, control and event registers
	always_comb begin
		wr_pend_next = acc & hwrite;
		wr_idx_next = idx;
		ctrl_next = ctrl_reg;
		trig_en_next = trig_en_reg;
		evt_clr = '0;
		abort_next = 1'b0;
		hrdata_next = hrdata_reg;
		if (wr_pend_reg) begin
			case (wr_idx_reg)
				IDX_CTRL: begin
					ctrl_next = hwdata[7:1];
					abort_next = 1'b1;
				end
				IDX_EVT_CLR: begin
					evt_clr = hwdata[NUM_EVT-1:0];
				end
				IDX_EVT_EN: begin
					ctrl_next[CTL_IE] = hwdata[EVT_SEQ];
					trig_en_next = hwdata[EVT_TRIG];
				end
				default: begin
					// Reserved and read-only locations drop writes
				end
			endcase
		end
		// A new event wins over a clear in the same cycle
		evt_next = (evt_reg & ~evt_clr) | {trig_fire, seq_done};
		if (rd_en) begin
			hrdata_next = 32'h0000_0000;
			case (idx)
				IDX_RSVD_A, IDX_RSVD_B: hrdata_next = 32'h0000_0000;
				IDX_CTRL: hrdata_next = {24'h00_0000, ctrl_next,
					ctrl_next[CTL_IE] & evt_reg[EVT_SEQ]};
				IDX_R6H: hrdata_next = {30'h0, res_reg[0][9:8]};
				IDX_R6L: hrdata_next = {24'h00_0000, res_reg[0][7:0]};
				IDX_R7H: hrdata_next = {30'h0, res_reg[1][9:8]};
				IDX_R7L: hrdata_next = {24'h00_0000, res_reg[1][7:0]};
				IDX_CHAN_STAT: hrdata_next = {24'h00_0000, chdone_reg, 6'h00};
				IDX_EVT_STAT: hrdata_next = {30'h0, evt_reg};
				IDX_EVT_EN: hrdata_next = {30'h0, trig_en_next, ctrl_next[CTL_IE]};
				default: hrdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= IDX_RSVD_A;
			ctrl_reg <= CTRL_RESET;
			trig_en_reg <= 1'b0;
			evt_reg <= EVT_RESET;
			abort_reg <= 1'b0;
			hrdata_reg <= RDATA_RESET;
		end else begin
			wr_pend_reg <= wr_pend_next;
			wr_idx_reg <= wr_idx_next;
			ctrl_reg <= ctrl_next;
			trig_en_reg <= trig_en_next;
			evt_reg <= evt_next;
			abort_reg <= abort_next;
			hrdata_reg <= hrdata_next;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign conv_abort = abort_reg;
	assign irq = (ctrl_reg[CTL_IE] & evt_reg[EVT_SEQ])
		| (trig_en_reg & evt_reg[EVT_TRIG]);

	// Result registers and conversion-complete flags, one per channel
	for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
		localparam logic [5:0] HI_IDX = 6'(IDX_R6H + 2 * g);
		localparam logic [5:0] LO_IDX = 6'(IDX_R6L + 2 * g);
		localparam logic [CHAN_W-1:0] CH = CHAN_W'(FIRST_CHAN + g);
		logic hit;
		logic res_acc;
		logic res_rd;
		logic clr;
		logic armed_reg;
		logic armed_next;
		logic chdone_next;
		logic [RES_W-1:0] res_next;

		always_comb begin
			hit = res_valid & (res_chan == CH);
			res_acc = acc & ((idx == HI_IDX) | (idx == LO_IDX));
			res_rd = res_acc & ~hwrite;
			if (ctrl_reg[CTL_FCLR]) begin
				clr = res_acc;
			end else begin
				clr = armed_reg & res_rd;
			end
			chdone_next = hit | (chdone_reg[g] & ~clr);
			armed_next = chdone_next & ((rd_en & (idx == IDX_CHAN_STAT) & chdone_reg[g])
				| (armed_reg & ~clr));
			res_next = hit ? res_data : res_reg[g];
		end

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				chdone_reg[g] <= 1'b0;
				armed_reg <= 1'b0;
				res_reg[g] <= RES_RESET;
			end else begin
				chdone_reg[g] <= chdone_next;
				armed_reg <= armed_next;
				res_reg[g] <= res_next;
			end
		end

		fast_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
			ctrl_reg[CTL_FCLR] && res_acc && !hit |=> !chdone_reg[g])
			else $error("fast clear left channel flag set");
		normal_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
			!ctrl_reg[CTL_FCLR] && !armed_reg && chdone_reg[g] |=> chdone_reg[g])
			else $error("channel flag cleared without status read first");
	end

	// Power and recovery sequencing
	assign halt = wait_mode & ctrl_reg[CTL_WPD];
	assign run = ctrl_reg[CTL_PWR] & ~halt;

	always_comb begin
		pwr_next = pwr_reg;
		cnt_next = cnt_reg;
		case (pwr_reg)
			PWR_OFF: begin
				cnt_next = '0;
				if (run) begin
					pwr_next = PWR_RECOVER;
				end
			end
			PWR_RECOVER: begin
				if (!run) begin
					pwr_next = PWR_OFF;
				end else if (cnt_reg == RCV_W'(RECOVERY_CYC - 1)) begin
					pwr_next = PWR_READY;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			PWR_READY: begin
				if (!run) begin
					pwr_next = PWR_OFF;
				end
			end
			default: begin
				pwr_next = PWR_OFF;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_reg <= PWR_OFF;
			cnt_reg <= '0;
		end else begin
			pwr_reg <= pwr_next;
			cnt_reg <= cnt_next;
		end
	end

	assign conv_enable = (pwr_reg != PWR_OFF);
	assign conv_settled = (pwr_reg == PWR_READY);

	adcct_trig_detect u_trig (
		.hclk(hclk),
		.hresetn(hresetn),
		.trig_in(trig_pin),
		.trigger_enable(ctrl_reg[CTL_TEN]),
		.trigger_level_select(ctrl_reg[CTL_TLE]),
		.trigger_polarity(ctrl_reg[CTL_TPOL]),
		.trig_fire(trig_fire)
	);
	assign conv_trigger = trig_fire;

	rsvd_read_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_en && (idx == IDX_RSVD_A || idx == IDX_RSVD_B) |=> hrdata == 32'h0000_0000)
		else $error("reserved location read nonzero");
	ctrl_abort_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_reg && wr_idx_reg == IDX_CTRL |=> conv_abort)
		else $error("control write did not abort");
	abort_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
		conv_abort |-> $past(wr_pend_reg) && $past(wr_idx_reg) == IDX_CTRL)
		else $error("abort without a control write");
	power_recover_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(conv_settled) |-> $past(conv_enable, RCV_A) && !$past(conv_enable, RCV_A1))
		else $error("recovery period length wrong");
	wait_halt_a: assert property (@(posedge hclk) disable iff (!hresetn)
		halt |=> !conv_enable && !conv_settled)
		else $error("converter kept running in wait with power down");
	wait_resume_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(halt) && ctrl_reg[CTL_PWR] |=> conv_enable && !conv_settled)
		else $error("conversion did not resume after wait");
	seq_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_done && ctrl_reg[CTL_IE]
		&& !(wr_pend_reg && (wr_idx_reg == IDX_EVT_EN || wr_idx_reg == IDX_CTRL)) |=> irq)
		else $error("sequence complete raised no interrupt");
	irq_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		irq && !(wr_pend_reg && (wr_idx_reg == IDX_EVT_CLR || wr_idx_reg == IDX_EVT_EN
		|| wr_idx_reg == IDX_CTRL)) |=> irq)
		else $error("interrupt dropped before clear");
	flag_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_en && idx == IDX_CTRL && !wr_pend_reg
		|=> hrdata[0] == ($past(ctrl_reg[CTL_IE]) && $past(evt_reg[EVT_SEQ])))
		else $error("control bit 0 read wrong");

endmodule : adcct_top

// >>> rtl/adcct_trig_detect.sv
`timescale 1ns/100ps
module adcct_trig_detect
	import adcct_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic trig_in,
	input wire logic trigger_enable,
	input wire logic trigger_level_select,
	input wire logic trigger_polarity,
	output logic trig_fire
);

	logic prev_reg;
	logic prev_next;
	logic fire_reg;
	logic fire_next;

	always_comb begin
		prev_next = trig_in;
		fire_next = 1'b0;
		if (trigger_enable) begin
			if (trigger_level_select) begin
				fire_next = (trig_in == trigger_polarity);
			end else if (trigger_polarity) begin
				fire_next = trig_in & ~prev_reg;
			end else begin
				fire_next = ~trig_in & prev_reg;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_reg <= 1'b0;
			fire_reg <= 1'b0;
		end else begin
			prev_reg <= prev_next;
			fire_reg <= fire_next;
		end
	end

	assign trig_fire = fire_reg;

	trig_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
		trigger_enable && trigger_level_select && (trig_in == trigger_polarity) |=> trig_fire)
		else $error("level trigger not fired");
	trig_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!trigger_enable || (!trigger_level_select && (trig_in == $past(trig_in)))
		|=> !trig_fire)
		else $error("trigger fired while disabled or without an edge");

endmodule : adcct_trig_detect
